// *** logic/touch_detect_config.sv ***
`timescale 1ns/1ps
`include "touch_detect_consts.svh"

module touch_detect_config #(
  parameter int unsigned NUM_CHAN   = `TD_NUM_CHAN,
  parameter int unsigned DELTA_W    = `TD_DELTA_W,
  parameter int unsigned THRESH_W   = `TD_THRESH_W,
  parameter int unsigned BASE_W     = `TD_BASE_W,
  parameter int unsigned LOW_LIMIT  = `TD_SCL_LOW_CYCLES,
  parameter int unsigned IDLE_LIMIT = `TD_BUS_IDLE_CYCLES
) (
  input  wire logic                            ref_clk,
  input  wire logic                            resetn,
  input  wire logic                            ce,
  input  wire touch_detect_pkg::reg_req_t      regReq,
  output logic [7:0]                           regRdData,
  input  wire logic                            sampleValid,
  input  wire logic [NUM_CHAN*DELTA_W-1:0]     deltaIn,
  input  wire logic [NUM_CHAN*THRESH_W-1:0]    threshIn,
  output logic [NUM_CHAN-1:0]                  touchState,
  input  wire logic                            baseValid,
  input  wire logic [BASE_W-1:0]               baseCountIn,
  output logic [BASE_W-1:0]                    baseCountShown,
  input  wire logic                            posValid,
  input  wire logic [`TD_SLIDER_W-1:0]         posIn,
  output logic [`TD_SLIDER_W-1:0]              sliderValue,
  output logic                                 sliderReportMode,
  input  wire touch_detect_pkg::bus_lines_t    busLines,
  input  wire touch_detect_pkg::bus_events_t   busEvents,
  output logic                                 busAbort,
  output logic                                 busIdleReset,
  output logic                                 busIgnore
);

  localparam int unsigned SCALED_W = DELTA_W + 8;
  localparam int unsigned CW       = $clog2(((LOW_LIMIT > IDLE_LIMIT) ? LOW_LIMIT : IDLE_LIMIT) + 2);

  // =============================================================
  // Decode helpers
  function automatic logic [2:0] confirmNeed(input logic [7:0] reg8);
    logic [2:0] code;
    code = reg8[`TD_CONFIRM_MSB:0];
    return (code < `TD_CONFIRM_MIN) ? `TD_CONFIRM_MIN : code;
  endfunction : confirmNeed

  function automatic logic [3:0] baseShift(input logic [7:0] reg8);
    logic [3:0] code;
    code = reg8[`TD_BASE_MSB:`TD_BASE_LSB];
    return (code > `TD_BASE_MAX_SHIFT) ? `TD_BASE_MAX_SHIFT : code;
  endfunction : baseShift

  function automatic logic [2:0] gainShiftOf(input logic [7:0] reg8);
    logic [2:0] code;
    code = reg8[`TD_GAIN_MSB:`TD_GAIN_LSB];
    return `TD_GAIN_MAX_SHIFT - code;
  endfunction : gainShiftOf

  // =============================================================
  // Registers
  logic [7:0]               confirmReg;
  logic [7:0]               gainReg;
  logic [7:0]               globalReg;
  logic [7:0]               next_confirmReg;
  logic [7:0]               next_gainReg;
  logic [7:0]               next_globalReg;
  logic [7:0]               next_regRdData;
  logic [`TD_SLIDER_W-1:0]  next_sliderValue;
  logic                     next_sliderReportMode;
  logic                     slideMode;

  assign slideMode = globalReg[`TD_SLIDER_MODE_BIT];

  always_comb begin
    next_confirmReg = confirmReg;
    next_gainReg    = gainReg;
    next_globalReg  = globalReg;
    if (regReq.wr) begin
      case (regReq.addr)
        `TD_ADDR_CONFIRM: begin
          next_confirmReg = regReq.data & `TD_CONFIRM_MASK;
        end
        `TD_ADDR_GAIN: begin
          next_gainReg = regReq.data & `TD_GAIN_MASK;
        end
        `TD_ADDR_GLOBAL: begin
          next_globalReg = regReq.data;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      confirmReg <= `TD_RST_CONFIRM;
      gainReg    <= `TD_RST_GAIN;
      globalReg  <= `TD_RST_GLOBAL;
    end else if (ce) begin
      confirmReg <= next_confirmReg;
      gainReg    <= next_gainReg;
      globalReg  <= next_globalReg;
    end
  end

  // =============================================================
  // Slider register, sensor index or host-written volume
  always_comb begin
    next_sliderValue      = sliderValue;
    next_sliderReportMode = next_globalReg[`TD_SLIDER_MODE_BIT];
    if (posValid && !slideMode) begin
      next_sliderValue = posIn;
    end
    if (regReq.wr && (regReq.addr == `TD_ADDR_SLIDER) && slideMode) begin
      next_sliderValue = regReq.data[`TD_SLIDER_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sliderValue      <= `TD_RST_SLIDER;
      sliderReportMode <= `TD_RST_SLIDER_MODE;
    end else if (ce) begin
      sliderValue      <= next_sliderValue;
      sliderReportMode <= next_sliderReportMode;
    end
  end

  // =============================================================
  // Read data, held until the next read
  always_comb begin
    next_regRdData = regRdData;
    if (regReq.rd) begin
      case (regReq.addr)
        `TD_ADDR_CONFIRM: next_regRdData = confirmReg;
        `TD_ADDR_GAIN:    next_regRdData = gainReg;
        `TD_ADDR_GLOBAL:  next_regRdData = globalReg;
        `TD_ADDR_SLIDER:  next_regRdData = {1'b0, sliderValue};
        default:          next_regRdData = `TD_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= `TD_RST_RDDATA;
    end else if (ce) begin
      regRdData <= next_regRdData;
    end
  end

  // =============================================================
  // Per-channel scaling, compare and debounce
  logic [2:0] gainShift;
  logic [2:0] need;

  assign gainShift = gainShiftOf(gainReg);
  assign need      = confirmNeed(confirmReg);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : gChan
      logic signed [SCALED_W-1:0] scaled;
      logic                       above;
      assign scaled = $signed(SCALED_W'($signed(deltaIn[ch*DELTA_W +: DELTA_W]))) <<< gainShift;
      assign above  = (scaled > $signed(SCALED_W'(0))) &&
                      ($unsigned(scaled) > (SCALED_W + THRESH_W)'(threshIn[ch*THRESH_W +: THRESH_W]));
      touch_debounce_chan uDeb (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .ce          (ce),
        .sampleValid (sampleValid),
        .above       (above),
        .need        (need),
        .touched     (touchState[ch])
      );
    end
  endgenerate

  // =============================================================
  // Baseline presentation, separate from detection
  logic [BASE_W-1:0] next_baseCountShown;

  always_comb begin
    next_baseCountShown = baseCountShown;
    if (baseValid) begin
      next_baseCountShown = baseCountIn >> baseShift(gainReg);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      baseCountShown <= '0;
    end else if (ce) begin
      baseCountShown <= next_baseCountShown;
    end
  end

  // =============================================================
  // Bus timeout and deep-sleep link handling
  logic timeoutEn;
  logic sclLowAbort;
  logic idleReset;

  assign timeoutEn = globalReg[`TD_TIMEOUT_BIT];

  bus_timeout_watch #(
    .LOW_LIMIT  (LOW_LIMIT),
    .IDLE_LIMIT (IDLE_LIMIT),
    .CW         (CW)
  ) uWatch (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .ce          (ce),
    .lines       (busLines),
    .enable      (timeoutEn),
    .idleAllowed (!busEvents.deepSleep),
    .sclLowAbort (sclLowAbort),
    .idleReset   (idleReset)
  );

  touch_detect_pkg::link_state_t linkState;
  touch_detect_pkg::link_state_t next_linkState;

  always_comb begin
    next_linkState = linkState;
    case (linkState)
      touch_detect_pkg::LISTEN: begin
        if (busEvents.foreignAddr) begin
          next_linkState = touch_detect_pkg::FOREIGN;
        end
      end
      touch_detect_pkg::FOREIGN: begin
        if (busEvents.stopSeen || (idleReset && !busEvents.deepSleep)) begin
          next_linkState = touch_detect_pkg::LISTEN;
        end else if (busEvents.deepSleep) begin
          next_linkState = touch_detect_pkg::WAIT_STOP;
        end
      end
      touch_detect_pkg::WAIT_STOP: begin
        if (busEvents.stopSeen) begin
          next_linkState = touch_detect_pkg::LISTEN;
        end
      end
      default: next_linkState = touch_detect_pkg::LISTEN;
    endcase
  end

  logic next_busAbort;
  logic next_busIdleReset;
  logic next_busIgnore;

  always_comb begin
    next_busAbort     = sclLowAbort;
    next_busIdleReset = idleReset;
    next_busIgnore    = (next_linkState == touch_detect_pkg::WAIT_STOP);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      linkState    <= touch_detect_pkg::LISTEN;
      busAbort     <= 1'b0;
      busIdleReset <= 1'b0;
      busIgnore    <= 1'b0;
    end else if (ce) begin
      linkState    <= next_linkState;
      busAbort     <= next_busAbort;
      busIdleReset <= next_busIdleReset;
      busIgnore    <= next_busIgnore;
    end
  end

endmodule : touch_detect_config

// *** logic/touch_detect_consts.svh ***
`ifndef TOUCH_DETECT_CONSTS_SVH
`define TOUCH_DETECT_CONSTS_SVH

// =============================================================
// Register map
`define TD_ADDR_CONFIRM      8'h1E
`define TD_ADDR_GAIN         8'h1F
`define TD_ADDR_GLOBAL       8'h20
`define TD_ADDR_SLIDER       8'h06

// =============================================================
// Reset values
`define TD_RST_CONFIRM       8'h03
`define TD_RST_GAIN          8'h2F
`define TD_RST_GLOBAL        8'h29
`define TD_RST_SLIDER        7'h00
`define TD_RST_SLIDER_MODE   1'b0
`define TD_RST_RDDATA        8'h00
`define TD_UNMAPPED_RD       8'h00

// =============================================================
// Field positions
`define TD_CONFIRM_MSB       2
`define TD_GAIN_MSB          6
`define TD_GAIN_LSB          4
`define TD_BASE_MSB          3
`define TD_BASE_LSB          0
`define TD_TIMEOUT_BIT       7
`define TD_SLIDER_MODE_BIT   6
`define TD_CONFIRM_MASK      8'h07
`define TD_GAIN_MASK         8'h7F

// =============================================================
// Decode limits
`define TD_CONFIRM_MIN       3'h1
`define TD_GAIN_MAX_SHIFT    3'h7
`define TD_BASE_MAX_SHIFT    4'h8

// =============================================================
// Widths and counts
`define TD_NUM_CHAN          14
`define TD_DELTA_W           8
`define TD_THRESH_W          16
`define TD_BASE_W            16
`define TD_SLIDER_W          7

// =============================================================
// Bus timing
`define TD_CLK_PERIOD_NS     10
`define TD_SCL_LOW_NS        30000000
`define TD_BUS_IDLE_NS       150000
`define TD_SCL_LOW_CYCLES    (`TD_SCL_LOW_NS / `TD_CLK_PERIOD_NS)
`define TD_BUS_IDLE_CYCLES   (`TD_BUS_IDLE_NS / `TD_CLK_PERIOD_NS)

`endif

// *** logic/touch_detect_pkg.sv ***
package touch_detect_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  typedef struct packed {
    logic foreignAddr;
    logic stopSeen;
    logic deepSleep;
  } bus_events_t;

  typedef enum logic [1:0] {
    LISTEN    = 2'b00,
    FOREIGN   = 2'b01,
    WAIT_STOP = 2'b11
  } link_state_t;

endpackage : touch_detect_pkg

// *** logic/touch_debounce_chan.sv ***
`timescale 1ns/1ps
`include "touch_detect_consts.svh"

module touch_debounce_chan (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       sampleValid,
  input  wire logic       above,
  input  wire logic [2:0] need,
  output logic            touched
);

  logic [2:0] runLen;
  logic [2:0] next_runLen;
  logic       next_touched;

  // =============================================================
  // Run of samples disagreeing with the current state
  always_comb begin
    next_runLen  = runLen;
    next_touched = touched;
    if (sampleValid) begin
      if (above != touched) begin
        if (runLen + 3'h1 >= need) begin
          next_touched = above;
          next_runLen  = 3'h0;
        end else begin
          next_runLen = runLen + 3'h1;
        end
      end else begin
        next_runLen = 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      runLen  <= 3'h0;
      touched <= 1'b0;
    end else if (ce) begin
      runLen  <= next_runLen;
      touched <= next_touched;
    end
  end

endmodule : touch_debounce_chan

// *** logic/bus_timeout_watch.sv ***
`timescale 1ns/1ps
`include "touch_detect_consts.svh"

module bus_timeout_watch #(
  parameter int unsigned LOW_LIMIT  = `TD_SCL_LOW_CYCLES,
  parameter int unsigned IDLE_LIMIT = `TD_BUS_IDLE_CYCLES,
  parameter int unsigned CW         = 22
) (
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  input  wire touch_detect_pkg::bus_lines_t lines,
  input  wire logic                      enable,
  input  wire logic                      idleAllowed,
  output logic                           sclLowAbort,
  output logic                           idleReset
);

  localparam logic [CW-1:0] LOW_END  = CW'(LOW_LIMIT + 1);
  localparam logic [CW-1:0] IDLE_END = CW'(IDLE_LIMIT + 1);

  logic [CW-1:0] lowCnt;
  logic [CW-1:0] idleCnt;
  logic [CW-1:0] next_lowCnt;
  logic [CW-1:0] next_idleCnt;
  logic          next_sclLowAbort;
  logic          next_idleReset;

  // =============================================================
  // Clock-low and both-high timers, at most one pulse per episode
  always_comb begin
    next_lowCnt      = lowCnt;
    next_idleCnt     = idleCnt;
    next_sclLowAbort = 1'b0;
    next_idleReset   = 1'b0;
    if (!enable || lines.scl) begin
      next_lowCnt = '0;
    end else if (lowCnt != LOW_END) begin
      next_lowCnt      = lowCnt + CW'(1);
      next_sclLowAbort = (lowCnt + CW'(1) == LOW_END);
    end
    if (!enable || !lines.scl || !lines.sda) begin
      next_idleCnt = '0;
    end else if (idleCnt != IDLE_END) begin
      next_idleCnt   = idleCnt + CW'(1);
      next_idleReset = idleAllowed && (idleCnt + CW'(1) == IDLE_END);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt      <= '0;
      idleCnt     <= '0;
      sclLowAbort <= 1'b0;
      idleReset   <= 1'b0;
    end else if (ce) begin
      lowCnt      <= next_lowCnt;
      idleCnt     <= next_idleCnt;
      sclLowAbort <= next_sclLowAbort;
      idleReset   <= next_idleReset;
    end
  end

endmodule : bus_timeout_watch

// *** verification/touch_detect_config_props.sv ***
`timescale 1ns/1ps
module touch_detect_config_props #(
  parameter int unsigned NUM_CHAN = 14,
  parameter int unsigned BASE_W   = 16
) (
  input wire logic                          ref_clk,
  input wire logic                          resetn,
  input wire logic                          ce,
  input wire touch_detect_pkg::reg_req_t    regReq,
  input wire logic                          sampleValid,
  input wire logic [NUM_CHAN-1:0]           touchState,
  input wire logic                          baseValid,
  input wire logic [BASE_W-1:0]             baseCountIn,
  input wire logic [BASE_W-1:0]             baseCountShown,
  input wire logic                          posValid,
  input wire logic [6:0]                    posIn,
  input wire logic [6:0]                    sliderValue,
  input wire logic                          sliderReportMode,
  input wire touch_detect_pkg::bus_lines_t  busLines,
  input wire touch_detect_pkg::bus_events_t busEvents,
  input wire logic                          busAbort,
  input wire logic                          busIdleReset,
  input wire logic                          busIgnore
);
  // ===========================================
  // Shadow of the timeout enable bit
  logic toEn;
  logic next_toEn;
  always_comb begin
    next_toEn = toEn;
    if (ce && regReq.wr && regReq.addr == 8'h20) next_toEn = regReq.data[7];
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) toEn <= 1'b0;
    else toEn <= next_toEn;
  end
  // ===========================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_touch_stable: assert property (!sampleValid |=> $stable(touchState))
    else $error("touch state moved without a sample");
  chk_base_shrink: assert property (baseValid && ce |=> baseCountShown <= $past(baseCountIn))
    else $error("shown baseline above raw baseline");
  chk_timeout_off: assert property (!toEn [*3] |-> !busAbort && !busIdleReset)
    else $error("bus timeout pulse while disabled");
  chk_abort_cause: assert property (busAbort |-> $past(!busLines.scl, 3))
    else $error("abort without clock low");
  chk_abort_pulse: assert property (busAbort |=> !busAbort)
    else $error("abort longer than one cycle");
  chk_idle_cause: assert property (busIdleReset |-> $past(busLines.scl && busLines.sda, 3))
    else $error("idle reset without idle lines");
  chk_sleep_idle: assert property (busEvents.deepSleep [*3] |-> !busIdleReset)
    else $error("idle reset in deep sleep");
  chk_ignore_rise: assert property ($rose(busIgnore) |-> $past(busEvents.deepSleep))
    else $error("ignore raised outside deep sleep");
  chk_ignore_stop: assert property (busIgnore && busEvents.stopSeen && ce |=> !busIgnore)
    else $error("ignore kept after stop");
  chk_slider_load: assert property (posValid && ce && !sliderReportMode && !regReq.wr
    |=> sliderValue == $past(posIn))
    else $error("slider position not loaded");
  chk_slider_hold: assert property (sliderReportMode && !regReq.wr |=> $stable(sliderValue))
    else $error("slider volume changed without write");
endmodule : touch_detect_config_props

bind touch_detect_config touch_detect_config_props #(.NUM_CHAN(NUM_CHAN), .BASE_W(BASE_W)) u_props (.*);

// *** verification/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic                  ref_clk,
  output touch_detect_pkg::reg_req_t regReq
);
  initial regReq = '0;
  // One-cycle strobe, launched and dropped on falling edges
  task automatic access(input logic isWr, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regReq = {isWr, !isWr, a, d};
    @(negedge ref_clk);
    regReq = '0;
  endtask : access
endmodule : host_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int NC = 14;
  logic                          ref_clk = 1'b0;
  logic                          resetn = 1'b0;
  logic                          ce = 1'b1;
  logic                          sampleValid = 1'b0;
  logic                          baseValid = 1'b0;
  logic                          posValid = 1'b0;
  logic                          rdSeen = 1'b0;
  logic [NC*8-1:0]               deltaIn = '0;
  logic [NC*16-1:0]              threshIn = '0;
  logic [15:0]                   baseCountIn = '0;
  logic [6:0]                    posIn = '0;
  touch_detect_pkg::bus_lines_t  busLines = 2'b10;
  touch_detect_pkg::bus_events_t busEvents = '0;
  touch_detect_pkg::reg_req_t    regReq;
  logic [7:0]                    regRdData;
  logic [NC-1:0]                 touchState;
  logic [15:0]                   baseCountShown;
  logic [6:0]                    sliderValue;
  logic                          sliderReportMode, busAbort, busIdleReset, busIgnore;
  logic [7:0]                    expQ[$];
  int                            nFail = 0, totalChecks = 0, nAbort = 0, nIdle = 0, cyc = 0;

  always #5 ref_clk = ~ref_clk;

  touch_detect_config #(.LOW_LIMIT(20), .IDLE_LIMIT(10)) dut (.*);
  host_model host (.ref_clk(ref_clk), .regReq(regReq));

  // ===========================================
  // Checking and reporting
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic endOfTest();
    if (nFail == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : endOfTest

  always @(posedge ref_clk) begin
    cyc++;
    rdSeen <= regReq.rd;
    if (cyc > 20000) begin
      nFail++;
      endOfTest();
    end
  end

  always @(negedge ref_clk) begin
    nAbort += int'(busAbort);
    nIdle += int'(busIdleReset);
    if (rdSeen) cmp(16'(regRdData), 16'(expQ.pop_front()));
  end

  // ===========================================
  // Stimulus helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic samp(input int n, input logic [7:0] d);
    repeat (n) begin
      @(negedge ref_clk);
      deltaIn[7:0] = d;
      sampleValid = 1'b1;
      @(negedge ref_clk);
      sampleValid = 1'b0;
    end
  endtask : samp

  task automatic posPulse();
    @(negedge ref_clk);
    posIn = 7'($urandom);
    posValid = 1'b1;
    @(negedge ref_clk);
    posValid = 1'b0;
  endtask : posPulse

  task automatic hold(input logic [1:0] lv, input int n);
    @(negedge ref_clk);
    busLines = lv;
    repeat (n) @(negedge ref_clk);
    busLines = 2'b10;
  endtask : hold

  // ===========================================
  // Main sequence
  initial begin
    void'($urandom(91179));
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    rd(8'h1E, 8'h03);
    rd(8'h1F, 8'h2F);
    rd(8'h20, 8'h29);
    rd(8'h40, 8'h00);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h07);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'h7F);
    for (int c = 0; c < 8; c++) begin
      int n;
      n = (c < 2) ? 1 : c;
      wr(8'h1E, 8'(c));
      samp(n - 1, 8'h01);
      samp(1, 8'h00);
      samp(n - 1, 8'h01);
      cmp(16'(touchState), 16'h0000);
      samp(1, 8'h01);
      cmp(16'(touchState), 16'h0001);
      samp(n - 1, 8'h00);
      cmp(16'(touchState), 16'h0001);
      samp(1, 8'h00);
      cmp(16'(touchState), 16'h0000);
    end
    wr(8'h1E, 8'h01);
    deltaIn = {NC{8'h01}};
    for (int g = 0; g < 8; g++) begin
      wr(8'h1F, {1'b0, 3'(g), 4'($urandom)});
      for (int ch = 0; ch < NC; ch++) threshIn[ch*16+:16] = 16'((1 << (7 - g)) - ((ch % 2 == 0) ? 1 : 0));
      samp(1, 8'h01);
      cmp(16'(touchState), 16'h1555);
    end
    for (int b = 0; b < 16; b++) begin
      wr(8'h1F, {4'h2, 4'(b)});
      @(negedge ref_clk);
      baseCountIn = 16'($urandom);
      baseValid = 1'b1;
      @(negedge ref_clk);
      baseValid = 1'b0;
      cmp(baseCountShown, baseCountIn >> ((b > 8) ? 8 : b));
    end
    posPulse();
    cmp(16'(sliderValue), 16'(posIn));
    wr(8'h06, 8'h55);
    rd(8'h06, {1'b0, posIn});
    wr(8'h20, 8'h69);
    wr(8'h06, 8'h55);
    rd(8'h06, 8'h55);
    posPulse();
    cmp(16'(sliderValue), 16'h0055);
    cmp(16'(sliderReportMode), 16'h0001);
    hold(2'b00, 40);
    hold(2'b11, 30);
    cmp(16'(nAbort + nIdle), 16'h0000);
    wr(8'h20, 8'hE9);
    hold(2'b00, 40);
    hold(2'b00, 15);
    cmp(16'(nAbort), 16'h0001);
    hold(2'b11, 30);
    cmp(16'(nIdle), 16'h0001);
    busEvents.deepSleep = 1'b1;
    hold(2'b11, 30);
    cmp(16'(nIdle), 16'h0001);
    busEvents.foreignAddr = 1'b1;
    @(negedge ref_clk);
    busEvents.foreignAddr = 1'b0;
    hold(2'b11, 30);
    cmp(16'(busIgnore), 16'h0001);
    busEvents.stopSeen = 1'b1;
    @(negedge ref_clk);
    busEvents.stopSeen = 1'b0;
    @(negedge ref_clk);
    cmp(16'(busIgnore), 16'h0000);
    busEvents.deepSleep = 1'b0;
    busEvents.foreignAddr = 1'b1;
    @(negedge ref_clk);
    busEvents.foreignAddr = 1'b0;
    hold(2'b11, 30);
    busEvents.deepSleep = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp(16'(busIgnore), 16'h0000);
    cmp(16'(nIdle), 16'h0002);
    busEvents.deepSleep = 1'b0;
    ce = 1'b0;
    samp(1, 8'h01);
    wr(8'h1E, 8'h05);
    cmp(16'(touchState), 16'h1555);
    ce = 1'b1;
    rd(8'h1E, 8'h01);
    samp(1, 8'h01);
    cmp(16'(touchState), 16'h3FFF);
    samp(1, 8'h80);
    cmp(16'(touchState), 16'h3FFE);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    rd(8'h1E, 8'h03);
    rd(8'h1F, 8'h2F);
    rd(8'h20, 8'h29);
    rd(8'h06, 8'h00);
    endOfTest();
  end
endmodule : tb_top
